// [verif/ictl_chk.sv]
/* Port checker for the interrupt controller top.
   Assumes a bind onto pic_ctl_top, one clock, reset active low. */
`timescale 1ns/1ps
module ictl_chk
	import pic_ctl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic avs_waitrequest,
	input wire logic [NUM_TRAP-1:0] trap_req,
	input wire logic core_accept,
	input wire logic irq_to_core,
	input wire logic [3:0] irq_level,
	input wire logic [SRC_IDX_W-1:0] irq_vector
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);
	property p_take; (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest;
	endproperty
	a_take: assert property (p_take) else $error("request not answered next cycle");
	property p_one; !avs_waitrequest |=> avs_waitrequest;
	endproperty
	a_one: assert property (p_one) else $error("waitrequest low too long");
	property p_idle; !(avs_read || avs_write) |-> avs_waitrequest;
	endproperty
	a_idle: assert property (p_idle) else $error("waitrequest low while idle");
	property p_unmap; avs_read && !avs_waitrequest && avs_address == 8'hfc
		|-> avs_readdata == UNMAPPED_READ;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
	property p_trap; $rose(|trap_req) |-> ##[1:8] (irq_to_core && irq_level[3]);
	endproperty
	a_trap: assert property (p_trap) else $error("trap not presented");
	property p_tlvl; irq_to_core && irq_level[3] |-> irq_level == {1'b1, irq_vector};
	endproperty
	a_tlvl: assert property (p_tlvl) else $error("trap level wrong");
	property p_lvl; irq_to_core |-> irq_level != 4'h0;
	endproperty
	a_lvl: assert property (p_lvl) else $error("level zero presented");
	property p_acc; core_accept && irq_to_core |=> !irq_to_core;
	endproperty
	a_acc: assert property (p_acc) else $error("request kept after accept");
	property p_usr; irq_to_core && !irq_level[3] |-> irq_vector < 3'(NUM_SRC);
	endproperty
	a_usr: assert property (p_usr) else $error("user vector out of range");
endmodule : ictl_chk

// [verif/ictl_core.sv]
/* Behavioural processor core: takes presented interrupts, returns later.
   Assumes hold is driven by the bench to make the core answer slowly. */
`timescale 1ns/1ps
module ictl_core (
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic irq_to_core,
	input wire logic hold,
	output logic core_accept,
	output logic core_return,
	output logic instr_retire
);
	logic [3:0] depth;
	logic [2:0] t;
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			core_accept <= 1'b0;
			core_return <= 1'b0;
			instr_retire <= 1'b0;
			depth <= 4'h0;
			t <= 3'h0;
		end else begin
			core_accept <= irq_to_core && !core_accept && !hold;
			core_return <= 1'b0;
			instr_retire <= !instr_retire;
			if (core_accept) begin
				depth <= depth + 4'h1;
				t <= 3'h5;
			end else if (depth != 4'h0) begin
				t <= t - 3'h1;
				if (t == 3'h0) begin
					core_return <= 1'b1;
					depth <= depth - 4'h1;
				end
			end
		end
	end
endmodule : ictl_core

// [verif/tb_top.sv]
/* Self-checking bench: register port, flags, arbitration, events, traps.
   Assumes the controller and core model above; reads scored from a queue. */
`timescale 1ns/1ps
module tb_top;
	import pic_ctl_pkg::*;
	logic core_clk = 1'b0, rstn = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
	logic [ADDR_W-1:0] avs_address = '0;
	logic [31:0] avs_writedata = '0, avs_readdata;
	logic avs_waitrequest, irq_to_core, irq_out, core_accept, core_return, instr_retire;
	logic hold = 1'b0;
	logic [NUM_SRC-1:0] periph_req = '0, pat;
	logic [NUM_TRAP-1:0] trap_req = '0;
	logic [3:0] irq_level;
	logic [SRC_IDX_W-1:0] irq_vector;
	logic [7:0] s = 8'h06;
	logic [31:0] exp_q[$];
	int miscompares = 0, n_checks = 0, cyc = 0;
	always #4 core_clk = ~core_clk;
	pic_ctl_top pic_ctl_top_i (.core_clk(core_clk), .rstn(rstn), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.periph_req(periph_req), .trap_req(trap_req), .core_accept(core_accept),
		.core_return(core_return), .instr_retire(instr_retire), .irq_to_core(irq_to_core),
		.irq_level(irq_level), .irq_vector(irq_vector), .irq_out(irq_out));
	ictl_core ictl_core_i (.core_clk(core_clk), .rstn(rstn), .irq_to_core(irq_to_core),
		.hold(hold), .core_accept(core_accept), .core_return(core_return),
		.instr_retire(instr_retire));
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr
	task automatic cmp_rd(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t read %h expected %h", $time, got, exp);
		end
	endtask : cmp_rd
	task automatic cmp_sig(input logic [7:0] got, input logic [7:0] exp);
		n_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t output %h expected %h", $time, got, exp);
		end
	endtask : cmp_sig
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge core_clk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		@(posedge core_clk);
		while (avs_waitrequest !== 1'b0) @(posedge core_clk);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask : bus
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		bus(1'b0, a, 32'h0000_0000);
	endtask : rd
	task automatic pulse(input logic [NUM_SRC-1:0] p, input logic [NUM_TRAP-1:0] tr);
		@(posedge core_clk);
		periph_req <= p;
		trap_req <= tr;
		@(posedge core_clk);
		periph_req <= '0;
		trap_req <= '0;
		repeat (8) @(posedge core_clk);
	endtask : pulse
	task automatic results();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : results
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		if (cyc == 6000) begin
			miscompares++;
			results();
		end
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0) begin
			if (exp_q.size() == 0)
				cmp_rd(avs_readdata, 32'hdead_beef);
			else
				cmp_rd(avs_readdata, exp_q.pop_front());
		end
	end
	initial begin
		repeat (2) @(posedge core_clk);
		rstn <= 1'b1;
		rd(OFF_PRIORITY, 32'h0000_4924);
		rd(8'hfc, 32'h0000_0000);
		for (int i = 0; i < 3; i++) begin
			s = lfsr(s);
			pat = s[4:0] | 5'h01;
			pulse(pat, 4'h0);
			cmp_sig({7'h0, irq_to_core}, 8'h00);
			rd(OFF_FLAG_ONE, {29'h0, pat[2:0]});
			rd(OFF_FLAG_TWO, {30'h0, pat[4:3]});
			bus(1'b1, OFF_FLAG_ONE, 32'h0000_0000);
			bus(1'b1, OFF_FLAG_TWO, 32'h0000_0000);
			rd(OFF_FLAG_ONE, 32'h0000_0000);
		end
		bus(1'b1, OFF_PRIORITY, 32'h0000_494b);
		rd(OFF_PRIORITY, 32'h0000_494b);
		hold <= 1'b1;
		bus(1'b1, OFF_ENABLE, 32'h0000_001f);
		bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_0001);
		pulse(5'h05, 4'h0);
		cmp_sig({irq_to_core, irq_level, irq_vector}, {1'b1, 4'h5, 3'h2});
		rd(OFF_VECTOR, 32'h0000_0012);
		hold <= 1'b0;
		repeat (6) @(posedge core_clk);
		rd(OFF_IRQ_STATUS, 32'h0000_0001);
		cmp_sig({7'h0, irq_out}, 8'h01);
		bus(1'b1, OFF_FLAG_ONE, 32'h0000_0000);
		bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_0000);
		bus(1'b1, OFF_IRQ_CLEAR, 32'h0000_0007);
		pulse(5'h00, 4'h2);
		rd(OFF_CONTROL_ONE, 32'h0000_0002);
		cmp_sig({7'h0, irq_out}, 8'h00);
		bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_0002);
		repeat (3) @(posedge core_clk);
		cmp_sig({7'h0, irq_out}, 8'h01);
		bus(1'b1, OFF_CONTROL_ONE, 32'h0000_0000);
		rd(OFF_CONTROL_ONE, 32'h0000_0000);
		hold <= 1'b1;
		rstn <= 1'b0;
		@(posedge core_clk);
		rstn <= 1'b1;
		rd(OFF_PRIORITY, 32'h0000_4924);
		bus(1'b1, OFF_PRIORITY, 32'h0000_0037);
		bus(1'b1, OFF_ENABLE, 32'h0000_0003);
		bus(1'b1, OFF_IRQ_ENABLE, 32'h0000_0004);
		bus(1'b1, OFF_TIMED_MASK, 32'h0000_0040);
		pulse(5'h02, 4'h0);
		cmp_sig({7'h0, irq_to_core}, 8'h00);
		pulse(5'h01, 4'h0);
		cmp_sig({irq_to_core, irq_level, irq_vector}, {1'b1, 4'h7, 3'h0});
		repeat (120) @(posedge core_clk);
		bus(1'b1, OFF_FLAG_ONE, 32'h0000_0002);
		repeat (2) @(posedge core_clk);
		cmp_sig({irq_to_core, irq_level, irq_vector}, {1'b1, 4'h6, 3'h1});
		rd(OFF_IRQ_STATUS, 32'h0000_0004);
		cmp_sig({7'h0, irq_out}, 8'h01);
		results();
	end
endmodule : tb_top
bind pic_ctl_top ictl_chk ictl_chk_i (.core_clk(core_clk), .rstn(rstn),
	.avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
	.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trap_req(trap_req),
	.core_accept(core_accept), .irq_to_core(irq_to_core), .irq_level(irq_level),
	.irq_vector(irq_vector));

// [verilog/pic_ctl_arbiter.sv]
/*
 * Combinational priority resolver: picks the highest-priority pending,
 * enabled request above the current masking level.
 * Assumes its inputs are registered state of the same clock.
 */
`timescale 1ns/1ps
module pic_ctl_arbiter
	import pic_ctl_pkg::*;
(
	input wire logic [NUM_SRC-1:0] pend,
	input wire logic [NUM_SRC-1:0] enab,
	input wire logic [3*NUM_SRC-1:0] prio,
	input wire logic [2:0] cpu_lvl,
	input wire logic timed_active,
	output logic found,
	output logic [SRC_IDX_W-1:0] win_idx,
	output logic [2:0] win_lvl
);
	logic [2:0] p;
	always_comb begin
		found = 1'b0;
		win_idx = '0;
		win_lvl = '0;
		p = '0;
		for (int i = 0; i < NUM_SRC; i++) begin
			p = prio[3*i +: 3];
			if (pend[i] && enab[i] && p > cpu_lvl && p != 3'h0
				&& !(timed_active && p <= TIMED_MASK_TOP)
				&& (!found || p > win_lvl)) begin
				found = 1'b1;
				win_idx = SRC_IDX_W'(i);
				win_lvl = p;
			end
		end
	end
endmodule : pic_ctl_arbiter

// [verilog/pic_ctl_pkg.sv]
/*
 * Package for the prioritized interrupt controller: register offsets,
 * field positions, reset values and source numbering.
 * Assumes a 32-bit Avalon-MM slave port with word addressing in bytes.
 */
package pic_ctl_pkg;
	// --------------------------------------------------------------
	// Sizes
	// --------------------------------------------------------------
	localparam int NUM_SRC = 5;
	localparam int NUM_TRAP = 4;
	localparam int SRC_IDX_W = 3;
	localparam int ADDR_W = 8;

	// --------------------------------------------------------------
	// Register byte offsets
	// --------------------------------------------------------------
	localparam logic [7:0] OFF_CONTROL_ONE = 8'h00;
	localparam logic [7:0] OFF_FLAG_ONE = 8'h04;
	localparam logic [7:0] OFF_FLAG_TWO = 8'h08;
	localparam logic [7:0] OFF_ENABLE = 8'h0c;
	localparam logic [7:0] OFF_PRIORITY = 8'h10;
	localparam logic [7:0] OFF_CORE_STATUS = 8'h14;
	localparam logic [7:0] OFF_TIMED_MASK = 8'h18;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h1c;
	localparam logic [7:0] OFF_IRQ_ENABLE = 8'h20;
	localparam logic [7:0] OFF_IRQ_CLEAR = 8'h24;
	localparam logic [7:0] OFF_VECTOR = 8'h28;

	// --------------------------------------------------------------
	// Fields
	// --------------------------------------------------------------
	localparam int NEST_DIS_BIT = 15;
	localparam int CPU_LVL_LSB = 5;
	localparam logic [7:0] MASK_ALL_OR = 8'h0e;
	localparam logic [2:0] LVL_MAX_USER = 3'h7;
	localparam logic [2:0] TIMED_MASK_TOP = 3'h6;
	localparam logic [3:0] TRAP_BASE_LVL = 4'h8;

	// Source numbering, also natural vector order (lower wins ties)
	localparam int SRC_SLAVE_TW = 0;
	localparam int SRC_MASTER_TW = 1;
	localparam int SRC_COMPARATOR = 2;
	localparam int SRC_SER_GENERAL = 3;
	localparam int SRC_SER_TRANSMIT = 4;

	// --------------------------------------------------------------
	// Reset values and unmapped read data
	// --------------------------------------------------------------
	localparam logic [2:0] RST_PRIORITY = 3'h4;
	localparam logic [7:0] RST_STATUS_LOW = 8'h00;
	localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

	// Interrupt-output event bits
	localparam int EV_ACCEPT = 0;
	localparam int EV_TRAP = 1;
	localparam int EV_TIMED_END = 2;
	localparam int NUM_EV = 3;
endpackage : pic_ctl_pkg

// [verilog/pic_ctl_top.sv]
/*
 * Prioritized interrupt controller with Avalon-MM register port.
 * Holds request flags, enables, priorities, core priority level, trap
 * flags, timed masking and the nesting stack of saved levels.
 * Assumes core strobes (accept, return, instruction retire) are
 * synchronous to core_clk; peripheral requests are synchronised here.
 */
// Added by the designer: the register offsets and the Avalon-MM interface to the registers.
// Behaviour
// - Nesting disabled blocks preemption of handlers by user sources; traps still preempt
// - Reset sets every source priority to 4
// - Request flag reads 1 after request
// - Only enabled sources reach the core
// - Uncleared flag re-takes interrupt after return
// - Return restores saved status and level
// - Trap flags sticky; set flag re-enters trap
// - ORing 0Eh into status masks users; the level is read from status bits 7:5 here, so 0Eh leaves it unchanged
// - Traps are never masked
// - Timed mask blocks levels 1-6, not 7
// - Timed mask lasts operand instruction count
// - Group one: comparator, master, slave bits
// - Group two: transmit bit 1, general 0
`timescale 1ns/1ps
module pic_ctl_top
	import pic_ctl_pkg::*;
(
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic [ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [NUM_SRC-1:0] periph_req,
	input wire logic [NUM_TRAP-1:0] trap_req,
	input wire logic core_accept,
	input wire logic core_return,
	input wire logic instr_retire,
	output logic irq_to_core,
	output logic [3:0] irq_level,
	output logic [SRC_IDX_W-1:0] irq_vector,
	output logic irq_out
);
	// --------------------------------------------------------------
	// State
	// --------------------------------------------------------------
	typedef enum logic [1:0] {ST_IDLE, ST_ANSWER} pic_bus_type;

	typedef struct packed {
		logic [NUM_SRC-1:0] req_s1;
		logic [NUM_SRC-1:0] req_s2;
		logic [NUM_SRC-1:0] req_prev;
		logic [NUM_TRAP-1:0] trap_s1;
		logic [NUM_TRAP-1:0] trap_s2;
		logic [NUM_SRC-1:0] flag;
		logic [NUM_SRC-1:0] enab;
		logic [3*NUM_SRC-1:0] prio;
		logic nest_dis;
		logic [NUM_TRAP-1:0] trap_flag;
		logic [7:0] status_low;
		logic [3:0] cpu_lvl;
		logic [7:0][7:0] stk_status;
		logic [2:0] stk_ptr;
		logic [13:0] timed_cnt;
		logic [NUM_EV-1:0] ev_stat;
		logic [NUM_EV-1:0] ev_en;
		pic_bus_type bus;
		logic [31:0] rdata;
		logic irq_to_core;
		logic [3:0] irq_level;
		logic [SRC_IDX_W-1:0] irq_vector;
		logic irq_out;
	} pic_state_type;

	pic_state_type st, next_st;
	logic found;
	logic [SRC_IDX_W-1:0] win_idx;
	logic [2:0] win_lvl;
	logic [15:0] grp_one;
	logic [15:0] grp_two;
	logic wr_hit;
	logic trap_pend;
	logic [1:0] trap_idx;
	logic [NUM_EV-1:0] ev_set;
	logic [NUM_SRC-1:0] clr_mask;

	function automatic logic [2:0] lvl_of(input logic [7:0] s);
		lvl_of = s[CPU_LVL_LSB +: 3];
	endfunction : lvl_of

	// --------------------------------------------------------------
	// Priority resolution
	// --------------------------------------------------------------
	pic_ctl_arbiter u_arb (
		.pend(st.flag),
		.enab(st.enab),
		.prio(st.prio),
		.cpu_lvl(st.cpu_lvl[3] ? LVL_MAX_USER : st.cpu_lvl[2:0]),
		.timed_active(st.timed_cnt != '0),
		.found(found),
		.win_idx(win_idx),
		.win_lvl(win_lvl)
	);

	// --------------------------------------------------------------
	// Next state
	// --------------------------------------------------------------
	always_comb begin
		next_st = st;
		ev_set = '0;
		wr_hit = 1'b0;
		trap_pend = 1'b0;
		trap_idx = '0;
		clr_mask = '0;
		grp_one = 16'h0000;
		grp_two = 16'h0000;
		grp_one[2] = st.flag[SRC_COMPARATOR];
		grp_one[1] = st.flag[SRC_MASTER_TW];
		grp_one[0] = st.flag[SRC_SLAVE_TW];
		grp_two[1] = st.flag[SRC_SER_TRANSMIT];
		grp_two[0] = st.flag[SRC_SER_GENERAL];

		next_st.req_s1 = periph_req;
		next_st.req_s2 = st.req_s1;
		next_st.req_prev = st.req_s2;
		next_st.trap_s1 = trap_req;
		next_st.trap_s2 = st.trap_s1;

		// Highest trap index is highest trap level
		for (int t = 0; t < NUM_TRAP; t++) begin
			if (st.trap_flag[t]) begin
				trap_pend = 1'b1;
				trap_idx = 2'(t);
			end
		end

		// Timed mask counts retired instructions
		if (st.timed_cnt != '0 && instr_retire) begin
			next_st.timed_cnt = st.timed_cnt - 14'd1;
			if (st.timed_cnt == 14'd1) begin
				ev_set[EV_TIMED_END] = 1'b1;
			end
		end

		// Bus slave: one wait cycle, answer in ST_ANSWER
		next_st.bus = ST_IDLE;
		// Read data registered on the take edge, so it stands while waitrequest is low
		if (st.bus == ST_IDLE && (avs_read || avs_write)) begin
			next_st.bus = ST_ANSWER;
			next_st.rdata = UNMAPPED_READ;
			if (avs_read) begin
				case (avs_address)
					OFF_CONTROL_ONE: next_st.rdata = {16'h0000, st.nest_dis, 11'h000,
						st.trap_flag};
					OFF_FLAG_ONE: next_st.rdata = {16'h0000, grp_one};
					OFF_FLAG_TWO: next_st.rdata = {16'h0000, grp_two};
					OFF_ENABLE: next_st.rdata = 32'(st.enab);
					OFF_PRIORITY: next_st.rdata = 32'(st.prio);
					OFF_CORE_STATUS: next_st.rdata = {20'h0_0000, st.cpu_lvl, st.status_low};
					OFF_TIMED_MASK: next_st.rdata = 32'(st.timed_cnt);
					OFF_IRQ_STATUS: next_st.rdata = 32'(st.ev_stat);
					OFF_IRQ_ENABLE: next_st.rdata = 32'(st.ev_en);
					OFF_VECTOR: next_st.rdata = {27'h000_0000, found, 1'b0, win_idx};
					default: next_st.rdata = UNMAPPED_READ;
				endcase
			end
		end
		if (st.bus == ST_ANSWER) begin
			wr_hit = avs_write;
		end

		if (wr_hit) begin
			case (avs_address)
				OFF_CONTROL_ONE: begin
					next_st.nest_dis = avs_writedata[NEST_DIS_BIT];
					next_st.trap_flag = st.trap_flag & avs_writedata[NUM_TRAP-1:0];
				end
				OFF_FLAG_ONE: begin
					next_st.flag[SRC_COMPARATOR] = avs_writedata[2];
					next_st.flag[SRC_MASTER_TW] = avs_writedata[1];
					next_st.flag[SRC_SLAVE_TW] = avs_writedata[0];
				end
				OFF_FLAG_TWO: begin
					next_st.flag[SRC_SER_TRANSMIT] = avs_writedata[1];
					next_st.flag[SRC_SER_GENERAL] = avs_writedata[0];
				end
				OFF_ENABLE: next_st.enab = avs_writedata[NUM_SRC-1:0];
				OFF_PRIORITY: next_st.prio = avs_writedata[3*NUM_SRC-1:0];
				OFF_CORE_STATUS: begin
					next_st.status_low = avs_writedata[7:0];
					if (!st.cpu_lvl[3]) begin
						next_st.cpu_lvl = {1'b0, lvl_of(avs_writedata[7:0])};
					end
				end
				OFF_TIMED_MASK: next_st.timed_cnt = avs_writedata[13:0];
				OFF_IRQ_ENABLE: next_st.ev_en = avs_writedata[NUM_EV-1:0];
				OFF_IRQ_CLEAR: next_st.ev_stat = st.ev_stat & ~avs_writedata[NUM_EV-1:0];
				default: ;
			endcase
		end

		// Return restores saved status and level; flags left set re-fire
		if (core_return && st.stk_ptr != '0) begin
			next_st.stk_ptr = st.stk_ptr - 3'd1;
			next_st.status_low = st.stk_status[st.stk_ptr - 3'd1];
			next_st.cpu_lvl = {1'b0, lvl_of(st.stk_status[st.stk_ptr - 3'd1])};
		end else if (core_accept && st.irq_to_core) begin
			next_st.stk_status[st.stk_ptr] = st.status_low;
			next_st.stk_ptr = st.stk_ptr + 3'd1;
			if (st.irq_level[3]) begin
				next_st.trap_flag = next_st.trap_flag;
				next_st.cpu_lvl = st.irq_level;
				ev_set[EV_TRAP] = 1'b1;
			end else begin
				next_st.cpu_lvl = st.nest_dis ? {1'b0, LVL_MAX_USER} : st.irq_level;
				next_st.status_low[CPU_LVL_LSB +: 3] = next_st.cpu_lvl[2:0];
				ev_set[EV_ACCEPT] = 1'b1;
			end
		end

		// Hardware set wins over software clear
		for (int i = 0; i < NUM_SRC; i++) begin
			if (st.req_s2[i] && !st.req_prev[i]) begin
				next_st.flag[i] = 1'b1;
			end
		end
		next_st.trap_flag = next_st.trap_flag | st.trap_s2;
		next_st.ev_stat = next_st.ev_stat | ev_set;

		// Presentation to core: traps first and unmaskable
		next_st.irq_to_core = 1'b0;
		next_st.irq_level = st.irq_level;
		next_st.irq_vector = st.irq_vector;
		if (trap_pend && (TRAP_BASE_LVL + 4'(trap_idx)) > st.cpu_lvl) begin
			next_st.irq_to_core = 1'b1;
			next_st.irq_level = TRAP_BASE_LVL + 4'(trap_idx);
			next_st.irq_vector = SRC_IDX_W'(trap_idx);
		end else if (found && !(st.nest_dis && st.stk_ptr != '0)) begin
			next_st.irq_to_core = 1'b1;
			next_st.irq_level = {1'b0, win_lvl};
			next_st.irq_vector = win_idx;
		end
		if (core_accept && st.irq_to_core) begin
			next_st.irq_to_core = 1'b0;
		end
		next_st.irq_out = |(next_st.ev_stat & next_st.ev_en);
		clr_mask = '0;
	end

	// --------------------------------------------------------------
	// Registers
	// --------------------------------------------------------------
	always_ff @(posedge core_clk or negedge rstn) begin
		if (!rstn) begin
			st <= '{default: '0, prio: {NUM_SRC{RST_PRIORITY}},
				status_low: RST_STATUS_LOW, bus: ST_IDLE};
		end else begin
			st <= next_st;
		end
	end

	assign avs_readdata = st.rdata;
	assign avs_waitrequest = !(st.bus == ST_ANSWER);
	assign irq_to_core = st.irq_to_core;
	assign irq_level = st.irq_level;
	assign irq_vector = st.irq_vector;
	assign irq_out = st.irq_out;
endmodule : pic_ctl_top
